// file: hw/rtr_pkg.sv
// Shared constants and state types for the two-wire clock/calendar RAM slave
package rtr_pkg;

  // ****************************************
  // Clock and bus timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;     // System clock period
  localparam int T_HIGH_NS     = 4000;   // Least link clock high time
  localparam int T_LOW_NS      = 4700;   // Least link clock low time
  // Least high time in system cycles, rounded up
  localparam int T_HIGH_CYC    = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least low time in system cycles, rounded up
  localparam int T_LOW_CYC     = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Memory layout
  // ****************************************
  localparam int         MEM_WORDS = 64;       // Byte locations reached by the pointer
  localparam int         PTR_W     = 6;        // Pointer width
  localparam logic [5:0] PTR_RST   = 6'h00;    // Pointer after reset or power fail
  localparam logic [5:0] PTR_ONE   = 6'h01;    // Pointer step
  localparam logic [7:0] MEM_RST   = 8'h00;    // Memory content after reset

  // ****************************************
  // Byte framing
  // ****************************************
  localparam logic [2:0] BIT_FIRST = 3'h0;     // Bit count at byte start
  localparam logic [2:0] BIT_LAST  = 3'h7;     // Bit count of the eighth bit
  localparam logic [2:0] BIT_ONE   = 3'h1;     // Bit count step

  // ****************************************
  // State types
  // ****************************************
  // Transfer phase of the slave
  typedef enum logic [2:0] {
    ST_IDLE,     // Bus free or not selected
    ST_ADDR,     // Receiving slave address byte
    ST_WORD,     // Receiving word address byte
    ST_WDATA,    // Receiving data bytes
    ST_RDATA,    // Transmitting data bytes
    ST_IGNORE    // Not addressed or read ended, wait for start or stop
  } rtr_st_e;

  // All system domain state
  typedef struct packed {
    logic [1:0]            scl_sy;    // Link clock synchroniser
    logic [1:0]            sda_sy;    // Data line synchroniser
    logic [1:0]            pf_sy;     // Supply low synchroniser
    logic [2:0]            tgl_sy;    // Bit toggle synchroniser plus history
    logic                  scl_d;     // Delayed synchronised clock
    logic                  sda_d;     // Delayed synchronised data
    rtr_st_e               st;        // Transfer phase
    logic                  ack_ph;    // Inside the ninth clock
    logic                  done;      // Eight bits seen
    logic [2:0]            cnt;       // Bit count in byte
    logic [7:0]            shreg;     // Shift register
    logic [5:0]            ptr;       // Word address pointer
    logic                  sda_oe_n;  // Data line drive, low pulls down
    logic [63:0][7:0]      mem;       // Byte storage
  } rtr_sys_s;

  // All link domain state
  typedef struct packed {
    logic bit_cap;   // Data sampled at link clock rise
    logic tgl;       // Flips once per link clock rise
  } rtr_lnk_s;

  // Reset value of system state
  localparam rtr_sys_s SYS_RST = '{st: ST_IDLE, sda_oe_n: 1'b1, default: '0};
  // Reset value of link state
  localparam rtr_lnk_s LNK_RST = '{default: '0};

endpackage : rtr_pkg

// file: hw/rtr_slave.sv
// Two-wire bus slave giving access to the 64 byte clock/calendar RAM
`timescale 1ns/10ps
module rtr_slave
  import rtr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h3c   // Slave address, value arbitrary
) (
  input  wire logic clock,                        // System clock
  input  wire logic nrst,                         // Asynchronous reset, active low
  input  wire logic scl,                          // Link clock from master
  input  wire logic sda_in,                       // Data line level
  output logic      sda_out,                      // Data line drive value
  output logic      sda_oe_n,                     // Data line drive enable, low drives
  input  wire logic below_power_fail_threshold    // Supply under trip point
);

  // ****************************************
  // Link domain: sample data on clock rise
  // ****************************************
  rtr_lnk_s lnk_ff;       // Link state
  rtr_lnk_s nxt_lnk;      // Next link state

  // Capture the bit and flag it with a toggle
  always_comb begin
    nxt_lnk         = lnk_ff;
    nxt_lnk.bit_cap = sda_in;
    nxt_lnk.tgl     = ~lnk_ff.tgl;
  end

  // Link state register, clocked only while the master clocks
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      lnk_ff <= LNK_RST;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ****************************************
  // System domain: decode events
  // ****************************************
  rtr_sys_s q_ff;         // System state
  rtr_sys_s nxt_q;        // Next system state

  logic       scl_s;      // Synchronised clock
  logic       sda_s;      // Synchronised data
  logic       pf;         // Synchronised supply low
  logic       bit_ev;     // Link clock rise seen, bit ready
  logic       scl_fall;   // Link clock fall seen
  logic       start_ev;   // Start condition
  logic       stop_ev;    // Stop condition
  logic [7:0] rx_byte;    // Shift register with new bit
  logic       active;     // Selected and taking part
  logic [7:0] rd_word;    // Byte at the pointer

  assign scl_s    = q_ff.scl_sy[1];
  assign sda_s    = q_ff.sda_sy[1];
  assign pf       = q_ff.pf_sy[1];
  // Toggle edge: captured bit has been stable for two system cycles
  // No timeout anywhere, so the slowest link clock is as good as the fastest
  assign bit_ev   = q_ff.tgl_sy[2] ^ q_ff.tgl_sy[1];
  assign scl_fall = q_ff.scl_d & ~scl_s;
  // Data edges while clock high are control conditions
  assign start_ev = scl_s & q_ff.scl_d & q_ff.sda_d & ~sda_s;
  assign stop_ev  = scl_s & q_ff.scl_d & ~q_ff.sda_d & sda_s;
  assign rx_byte  = {q_ff.shreg[6:0], lnk_ff.bit_cap};
  assign active   = (q_ff.st != ST_IDLE) && (q_ff.st != ST_IGNORE);
  assign rd_word  = q_ff.mem[q_ff.ptr];

  // ****************************************
  // System domain: protocol engine
  // ****************************************
  // Next state of synchronisers, framing and memory
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.scl_sy = {q_ff.scl_sy[0], scl};
    nxt_q.sda_sy = {q_ff.sda_sy[0], sda_in};
    nxt_q.pf_sy  = {q_ff.pf_sy[0], below_power_fail_threshold};
    nxt_q.tgl_sy = {q_ff.tgl_sy[1:0], lnk_ff.tgl};
    nxt_q.scl_d  = scl_s;
    nxt_q.sda_d  = sda_s;
    if (pf) begin
      // Abort, clear pointer, let go of the line, ignore inputs
      nxt_q.st       = ST_IDLE;
      nxt_q.ptr      = PTR_RST;
      nxt_q.sda_oe_n = 1'b1;
      nxt_q.ack_ph   = 1'b0;
      nxt_q.done     = 1'b0;
      nxt_q.cnt      = BIT_FIRST;
    end else if (start_ev) begin
      // Start or repeated start: expect the slave address
      nxt_q.st       = ST_ADDR;
      nxt_q.sda_oe_n = 1'b1;
      nxt_q.ack_ph   = 1'b0;
      nxt_q.done     = 1'b0;
      nxt_q.cnt      = BIT_FIRST;
    end else if (stop_ev) begin
      // Stop ends any transfer, pointer kept
      nxt_q.st       = ST_IDLE;
      nxt_q.sda_oe_n = 1'b1;
      nxt_q.ack_ph   = 1'b0;
      nxt_q.done     = 1'b0;
    end else if (active && bit_ev) begin
      if (!q_ff.ack_ph) begin
        // One of the eight data bits
        nxt_q.cnt = q_ff.cnt + BIT_ONE;
        if (q_ff.st != ST_RDATA) begin
          nxt_q.shreg = rx_byte;
        end
        if (q_ff.cnt == BIT_LAST) begin
          nxt_q.done = 1'b1;
          unique case (q_ff.st)
            // Foreign address: drop out without acknowledge
            ST_ADDR: begin
              if (rx_byte[7:1] != DEV_ADDR) begin
                nxt_q.st = ST_IGNORE;
              end
            end
            // Word address goes straight to the pointer
            ST_WORD: begin
              nxt_q.ptr = rx_byte[PTR_W-1:0];
            end
            // Data byte stored at the pointer
            ST_WDATA: begin
              nxt_q.mem[q_ff.ptr] = rx_byte;
            end
            ST_RDATA, ST_IDLE, ST_IGNORE: begin
            end
          endcase
        end
      end else begin
        // Ninth clock high
        if (q_ff.st == ST_WDATA) begin
          nxt_q.ptr = q_ff.ptr + PTR_ONE;
        end
        if (q_ff.st == ST_RDATA) begin
          if (lnk_ff.bit_cap) begin
            // Master withheld acknowledge: leave line high, wait stop
            nxt_q.st       = ST_IGNORE;
            nxt_q.sda_oe_n = 1'b1;
          end else begin
            nxt_q.ptr = q_ff.ptr + PTR_ONE;
          end
        end
      end
    end else if (active && scl_fall) begin
      if (!q_ff.ack_ph) begin
        if (q_ff.done) begin
          // Enter ninth bit: receiver pulls low, transmitter lets go
          nxt_q.ack_ph   = 1'b1;
          nxt_q.done     = 1'b0;
          nxt_q.sda_oe_n = (q_ff.st == ST_RDATA);
        end else if (q_ff.st == ST_RDATA) begin
          // Next transmit bit, changed only while clock low
          nxt_q.shreg    = {q_ff.shreg[6:0], 1'b0};
          nxt_q.sda_oe_n = q_ff.shreg[6];
        end
      end else begin
        // End of ninth bit: a receiver's acknowledge was held low across the whole high time, transmitter had let go
        nxt_q.ack_ph   = 1'b0;
        nxt_q.cnt      = BIT_FIRST;
        nxt_q.sda_oe_n = 1'b1;
        unique case (q_ff.st)
          ST_ADDR: begin
            if (q_ff.shreg[0]) begin
              // Read header: send byte at current pointer
              nxt_q.st       = ST_RDATA;
              nxt_q.shreg    = rd_word;
              nxt_q.sda_oe_n = rd_word[7];
            end else begin
              nxt_q.st = ST_WORD;
            end
          end
          ST_WORD: begin
            nxt_q.st = ST_WDATA;
          end
          ST_WDATA: begin
            nxt_q.st = ST_WDATA;
          end
          ST_RDATA: begin
            // Acknowledged: send the following location
            nxt_q.shreg    = rd_word;
            nxt_q.sda_oe_n = rd_word[7];
          end
          ST_IDLE, ST_IGNORE: begin
          end
        endcase
      end
    end
  end

  // System state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_ff <= SYS_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Open drain: only ever pull low
  assign sda_out  = 1'b0;
  assign sda_oe_n = q_ff.sda_oe_n;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic plain;            // No control condition and supply fine
  assign plain = !pf && !start_ev && !stop_ev;

  // Supply low clears pointer and returns to idle
  property p_pf_abort;
    pf |=> (q_ff.st == ST_IDLE) && (q_ff.ptr == PTR_RST);
  endproperty
  a_pf_abort: assert property (p_pf_abort) else $error("supply low did not abort");

  // Supply low keeps line released, start ignored
  property p_pf_ignore;
    pf && start_ev |=> (sda_oe_n && (q_ff.st != ST_ADDR)) [*2];
  endproperty
  a_pf_ignore: assert property (p_pf_ignore) else $error("input taken while low");

  // Start enters address phase
  property p_start;
    !pf && start_ev |=> (q_ff.st == ST_ADDR) && (q_ff.cnt == BIT_FIRST);
  endproperty
  a_start: assert property (p_start) else $error("start not recognised");

  // Stop releases line and idles
  property p_stop;
    !pf && !start_ev && stop_ev |=> (q_ff.st == ST_IDLE) && sda_oe_n;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not recognised");

  // Received write bytes are acknowledged on the ninth bit
  property p_ack_rx;
    plain && scl_fall && !q_ff.ack_ph && q_ff.done &&
      (q_ff.st inside {ST_WORD, ST_WDATA}) |=> !sda_oe_n && q_ff.ack_ph;
  endproperty
  a_ack_rx: assert property (p_ack_rx) else $error("byte not acknowledged");

  // Missing acknowledge from master releases the line
  property p_nack;
    plain && bit_ev && q_ff.ack_ph && (q_ff.st == ST_RDATA) && lnk_ff.bit_cap
      |=> (q_ff.st == ST_IGNORE) && sda_oe_n ##1 sda_oe_n;
  endproperty
  a_nack: assert property (p_nack) else $error("line held after no acknowledge");

  // Read pointer steps by one on master acknowledge
  property p_rd_step;
    plain && bit_ev && q_ff.ack_ph && (q_ff.st == ST_RDATA) && !lnk_ff.bit_cap
      |=> q_ff.ptr == $past(q_ff.ptr) + PTR_ONE;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read pointer not stepped");

  // Eighth data bit stores the byte at the pointer
  property p_store;
    plain && bit_ev && !q_ff.ack_ph && (q_ff.cnt == BIT_LAST) && (q_ff.st == ST_WDATA)
      |=> q_ff.mem[q_ff.ptr] == $past(rx_byte);
  endproperty
  a_store: assert property (p_store) else $error("write byte not stored");

  // Foreign address never acknowledged
  property p_foreign;
    plain && bit_ev && !q_ff.ack_ph && (q_ff.cnt == BIT_LAST) && (q_ff.st == ST_ADDR) &&
      (rx_byte[7:1] != DEV_ADDR) |=> (q_ff.st == ST_IGNORE) && sda_oe_n;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address taken");

  // Pointer wraps from the top location to zero
  property p_wrap;
    plain && bit_ev && q_ff.ack_ph && (q_ff.st == ST_WDATA) && (q_ff.ptr == 6'h3f)
      |=> q_ff.ptr == PTR_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  // ****************************************
  // Checks: line timing and pointer handling
  // ****************************************
  // Slave address acknowledged on the ninth bit
  property p_ack_addr;
    plain && scl_fall && !q_ff.ack_ph && q_ff.done && (q_ff.st == ST_ADDR)
      |=> !sda_oe_n && q_ff.ack_ph;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

  // Acknowledge drive holds until the clock falls
  property p_ack_hold;
    plain && q_ff.ack_ph && !sda_oe_n && !scl_fall |=> !sda_oe_n;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released early");

  // Line drive changes only while the clock is low
  property p_drive_low;
    plain && scl_s |=> $stable(sda_oe_n);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("line moved, clock high");

  // Transmitter lets go for the master's ninth bit
  property p_tx_rel;
    plain && scl_fall && !q_ff.ack_ph && q_ff.done && (q_ff.st == ST_RDATA)
      |=> sda_oe_n && q_ff.ack_ph;
  endproperty
  a_tx_rel: assert property (p_tx_rel) else $error("line kept for master bit");

  // Word address byte loads the pointer
  property p_word;
    plain && bit_ev && !q_ff.ack_ph && (q_ff.cnt == BIT_LAST) && (q_ff.st == ST_WORD)
      |=> q_ff.ptr == $past(rx_byte[PTR_W-1:0]);
  endproperty
  a_word: assert property (p_word) else $error("word address not loaded");

  // Write acknowledge clock steps the pointer
  property p_wr_step;
    plain && bit_ev && q_ff.ack_ph && (q_ff.st == ST_WDATA)
      |=> q_ff.ptr == $past(q_ff.ptr) + PTR_ONE;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer not stepped");

  // Withheld acknowledge leaves the pointer alone
  property p_rd_hold;
    plain && bit_ev && q_ff.ack_ph && (q_ff.st == ST_RDATA) && lnk_ff.bit_cap
      |=> q_ff.ptr == $past(q_ff.ptr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("pointer stepped on no ack");

  // Read header sends the byte at the pointer, top bit first
  property p_rd_first;
    plain && scl_fall && q_ff.ack_ph && (q_ff.st == ST_ADDR) && q_ff.shreg[0]
      |=> (q_ff.st == ST_RDATA) && (sda_oe_n == $past(rd_word[7]));
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("read header not served");

  // Stop keeps the pointer for a later bare read
  property p_stop_ptr;
    !pf && !start_ev && stop_ev |=> q_ff.ptr == $past(q_ff.ptr);
  endproperty
  a_stop_ptr: assert property (p_stop_ptr) else $error("stop moved the pointer");

  // Not addressed: stay out and keep the line released
  property p_ignore;
    plain && (q_ff.st == ST_IGNORE) |=> (q_ff.st == ST_IGNORE) && sda_oe_n;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored transfer answered");

  // Any number of data bytes: write phase never closes by itself
  property p_no_limit;
    plain && scl_fall && q_ff.ack_ph && (q_ff.st == ST_WDATA) |=> q_ff.st == ST_WDATA;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("write phase closed");

endmodule : rtr_slave

// file: tb/rtr_master.sv
// Two-wire bus master model that drives the slave's link
`timescale 1ns/10ps
module rtr_master (
  input  wire logic       clock,      // System clock, paces the link
  input  wire logic       sda_wire,   // Resolved data line
  output logic            scl,        // Link clock, stands high outside frames
  output logic            sda_oe_n,   // Low pulls the data line down
  output logic [7:0]      res_data,   // Acknowledge bit or byte read
  output logic            res_valid   // High for one cycle per result
);
  // ****************************************
  // Idle bus at time zero
  // ****************************************
  initial begin
    scl       = 1'b1;
    sda_oe_n  = 1'b1;
    res_data  = 8'h00;
    res_valid = 1'b0;
  end

  // ****************************************
  // Pacing, results and bit level
  // ****************************************
  // Wait cycles, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // Hand one result to the bench for one cycle
  task automatic emit(input logic [7:0] v);
    res_data  = v;
    res_valid = 1'b1;
    cyc(1);
    res_valid = 1'b0;
  endtask : emit

  // One bit; a change during clock high shows as unknown
  task automatic xfer_bit(input logic drv, output logic smp);
    logic s1;
    cyc(10);                                // Hold after the clock fall
    sda_oe_n = drv;
    cyc(84);
    scl = 1'b1;
    cyc(2);
    s1 = sda_wire;
    cyc(76);
    smp = (s1 === sda_wire) ? s1 : 1'bx;
    cyc(2);
    scl = 1'b0;
  endtask : xfer_bit

  // ****************************************
  // Byte and bus condition tasks
  // ****************************************
  // Send a byte MSB first, release for the ninth bit
  task automatic wr_byte(input logic [7:0] b);
    logic junk;
    logic ack;
    for (int i = 7; i >= 0; i--) xfer_bit(b[i], junk);
    xfer_bit(1'b1, ack);
    emit({7'h00, ack});
  endtask : wr_byte

  // Read a byte, then acknowledge or withhold it
  task automatic rd_byte(input logic nack);
    logic [7:0] d;
    logic       junk;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
    xfer_bit(nack, junk);
    emit(d);
  endtask : rd_byte

  // Start, or repeated start when the clock is low
  task automatic start_cond();
    if (scl === 1'b0) begin
      cyc(10);
      sda_oe_n = 1'b1;
      cyc(84);
      scl = 1'b1;
      cyc(94);
    end
    sda_oe_n = 1'b0;
    cyc(90);
    scl = 1'b0;
  endtask : start_cond

  // Stop, then leave the bus free
  task automatic stop_cond();
    cyc(10);
    sda_oe_n = 1'b0;
    cyc(84);
    scl = 1'b1;
    cyc(94);
    sda_oe_n = 1'b1;
    cyc(100);
  endtask : stop_cond
endmodule : rtr_master

// file: tb/testbench.sv
// Self-checking bench for the two-wire clock/calendar RAM slave
`timescale 1ns/10ps
module testbench
  import rtr_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [6:0] SLV = 7'h3c;       // Slave address, value arbitrary
  localparam logic [7:0] AW  = {SLV, 1'b0}; // Write header
  localparam logic [7:0] AR  = {SLV, 1'b1}; // Read header
  logic       clock;                        // System clock
  logic       nrst;                         // Reset, active low
  logic       pf;                           // Supply below trip point
  logic       scl;                          // Link clock
  logic       m_oe_n;                       // Master data drive
  logic       sda_out;                      // Slave data value
  logic       sda_oe_n;                     // Slave data drive
  logic [7:0] res_data;                     // Result from master
  logic       res_valid;                    // Result strobe
  wire        sda_wire;                     // Data line with pull-up
  logic [7:0] exp_q[$];                     // Expected results, oldest first
  logic [7:0] exp_mem [0:63];               // Expected memory image
  logic [7:0] d;                            // Random data byte
  int         fail_count = 0;               // Mismatches
  int         checks = 0;                   // Comparisons
  int         seed = 981;                   // Random seed

  assign sda_wire = m_oe_n & (sda_oe_n | sda_out);

  rtr_slave #(.DEV_ADDR(SLV)) i_rtr_slave (.clock(clock), .nrst(nrst), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .below_power_fail_threshold(pf));
  rtr_master i_rtr_master (.clock(clock), .sda_wire(sda_wire), .scl(scl),
    .sda_oe_n(m_oe_n), .res_data(res_data), .res_valid(res_valid));

  // ****************************************
  // Clock, checking and closing
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Each result takes the oldest note
  always @(posedge clock) begin
    if (res_valid === 1'b1) begin
      check(res_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  // Note the expectation, then run the byte
  task automatic wr(input logic [7:0] b, input logic nack);
    exp_q.push_back({7'h00, nack});
    i_rtr_master.wr_byte(b);
  endtask : wr

  task automatic rd(input logic nack, input logic [7:0] want);
    exp_q.push_back(want);
    i_rtr_master.rd_byte(nack);
  endtask : rd

  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    $display("mismatch at %0t: run timed out", $time);
    tally_and_finish();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    nrst = 1'b0;
    pf   = 1'b0;
    for (int i = 0; i < 64; i++) exp_mem[i] = MEM_RST;
    repeat (10) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clock);
    // Bare read after reset starts at location zero
    i_rtr_master.start_cond();
    wr(AR, 1'b0);
    rd(1'b1, exp_mem[0]);
    i_rtr_master.stop_cond();
    // Foreign address is not acknowledged
    i_rtr_master.start_cond();
    wr({SLV ^ 7'h01, 1'b0}, 1'b1);
    i_rtr_master.stop_cond();
    // Write four bytes from 62, upper word bits ignored, wraps
    i_rtr_master.start_cond();
    wr(AW, 1'b0);
    wr({2'($random(seed)), 6'h3e}, 1'b0);
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      exp_mem[(62 + k) % 64] = d;
      wr(d, 1'b0);
    end
    i_rtr_master.stop_cond();
    // Random read from 63 across the wrap, last byte withheld
    i_rtr_master.start_cond();
    wr(AW, 1'b0);
    wr(8'h3f, 1'b0);
    i_rtr_master.start_cond();
    wr(AR, 1'b0);
    rd(1'b0, exp_mem[63]);
    rd(1'b0, exp_mem[0]);
    rd(1'b1, exp_mem[1]);
    i_rtr_master.stop_cond();
    // Pointer kept at 1 after the withheld byte
    i_rtr_master.start_cond();
    wr(AR, 1'b0);
    rd(1'b1, exp_mem[1]);
    i_rtr_master.stop_cond();
    // Supply drops inside a data byte
    i_rtr_master.start_cond();
    wr(AW, 1'b0);
    wr(8'h05, 1'b0);
    fork
      begin
        repeat (400) @(posedge clock);
        #1 pf = 1'b1;
      end
      wr(8'ha5, 1'b1);
    join
    i_rtr_master.stop_cond();
    // Write attempt while the supply stays low
    i_rtr_master.start_cond();
    wr(AW, 1'b1);
    wr(8'h00, 1'b1);
    wr(~exp_mem[0], 1'b1);
    i_rtr_master.stop_cond();
    @(posedge clock);
    #1 pf = 1'b0;
    repeat (10) @(posedge clock);
    // Pointer cleared, location zero untouched
    i_rtr_master.start_cond();
    wr(AR, 1'b0);
    rd(1'b1, exp_mem[0]);
    i_rtr_master.stop_cond();
    repeat (5) @(posedge clock);
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule : testbench
